// [cbf_charger_ctrl.sv]
// charger and boost fault control: mode state, event flags, timers
// assumes comparator inputs are asynchronous levels, register port
// and transaction pulse synchronous to ref_clk
`timescale 1ns/1ps
`include "cbf_defs.svh"
module cbf_charger_ctrl #(
  parameter longint DPM_CYC =
    `CBF_DPM_DELAY_MS * 64'd1000 * `CBF_CLK_MHZ,
  parameter longint OLOAD_CYC =
    `CBF_OLOAD_MS * 64'd1000 * `CBF_CLK_MHZ,
  parameter longint BST_TMO_CYC =
    `CBF_BST_TMO_S * 64'd1000000 * `CBF_CLK_MHZ
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // valid transaction to this device completed
  input wire logic i2c_txn_done,
  // analog comparators, asynchronous
  input wire logic vbus_below_rev,
  input wire logic vbus_above_poor,
  input wire logic input_voltage_power_loop,
  input wire logic source_valid,
  input wire logic bat_overvoltage,
  input wire logic bat_below_short,
  input wire logic vbus_overvoltage,
  input wire logic boost_overload,
  input wire logic bat_above_max,
  input wire logic bat_below_min,
  input wire logic ind_current_low,
  input wire logic boost_output_node_low,
  // boost request pin
  input wire logic otg_pin,
  // power stage controls
  output logic reverse_block_switch,
  output logic converter_on,
  output logic boost_mode,
  output logic short_mode,
  output logic low_charge_limit,
  output logic hiz_mode,
  // status pin and interrupt
  output logic stat_o,
  output logic stat_oe,
  output logic int_n
);

  localparam int TW = `CBF_TMR_W;
  localparam logic [TW-1:0] DPM_LAST = TW'(DPM_CYC - 64'd1);
  localparam logic [TW-1:0] OLOAD_LIM = TW'(OLOAD_CYC);
  localparam logic [TW-1:0] BST_LAST = TW'(BST_TMO_CYC - 64'd1);

  cbf_pkg::cbf_regs_t st_reg;
  cbf_pkg::cbf_regs_t st_next;

  // ********************************************************
  // input synchronisation
  // ********************************************************

  logic [`CBF_N_CMP-1:0] cmp_raw;
  logic [`CBF_N_CMP-1:0] cmp_s;

  assign cmp_raw = {otg_pin, boost_output_node_low,
                    ind_current_low, bat_below_min,
                    bat_above_max, boost_overload,
                    vbus_overvoltage, bat_below_short,
                    bat_overvoltage, source_valid,
                    input_voltage_power_loop, vbus_above_poor,
                    vbus_below_rev};

  cbf_sync #(
    .W(`CBF_N_CMP)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .din(cmp_raw),
    .dout(cmp_s)
  );

  logic s_rev, s_poor, s_dpm, s_src, s_batov, s_short;
  logic s_busov, s_ol, s_bmax, s_bmin, s_ilow, s_plow, s_otg;

  assign {s_otg, s_plow, s_ilow, s_bmin, s_bmax, s_ol, s_busov,
          s_short, s_batov, s_src, s_dpm, s_poor, s_rev} = cmp_s;

  // ********************************************************
  // decode helpers
  // ********************************************************

  function automatic logic is_charge_mode(input logic [1:0] m);
    is_charge_mode = (m == `CBF_MODE_CHG) ||
                     (m == `CBF_MODE_CHG_AR);
  endfunction : is_charge_mode

  function automatic logic stat_drive(input logic [1:0] f,
                                      input logic charging);
    case (f)
      `CBF_STAT_AUTO: stat_drive = charging;
      `CBF_STAT_LOW: stat_drive = 1'b1;
      // 10 releases the pin, undefined 11 treated the same
      default: stat_drive = 1'b0;
    endcase
  endfunction : stat_drive

  // ********************************************************
  // next state
  // ********************************************************

  logic [1:0] mode;
  logic pin_on;
  logic boost_req;
  logic chg_req;
  logic rev_cond;
  logic bst_fault;
  logic charging;
  logic host_txn;

  always_comb begin
    st_next = st_reg;
    st_next.rdata = 8'h00;
    mode = st_reg.ctrl[`CBF_MODE_HI:`CBF_MODE_LO];
    host_txn = i2c_txn_done | reg_wr | reg_rd;
    bst_fault = 1'b0;

    // register writes; source insertion below sets the low charge limit bit over the written value
    if (reg_wr) begin
      case (reg_addr)
        `CBF_ADDR_CONTROL: begin
          st_next.ctrl = reg_wdata;
          if (reg_wdata[`CBF_MODE_HI:`CBF_MODE_LO] ==
              `CBF_MODE_BOOST) begin
            st_next.ovp_lock = 1'b0;
            st_next.pin_lock = 1'b0;
          end
        end
        `CBF_ADDR_CONFIG_C: st_next.cfgc = reg_wdata;
        default: ;
      endcase
    end

    // register reads, event registers clear on read
    if (reg_rd) begin
      case (reg_addr)
        `CBF_ADDR_CONTROL: st_next.rdata = st_reg.ctrl;
        `CBF_ADDR_CONFIG_C: st_next.rdata = st_reg.cfgc;
        `CBF_ADDR_CHG_EVT: begin
          st_next.rdata = st_reg.chg_evt;
          st_next.chg_evt = `CBF_EVT_RST;
        end
        `CBF_ADDR_BST_EVT: begin
          st_next.rdata = st_reg.bst_evt;
          st_next.bst_evt = `CBF_EVT_RST;
        end
        default: st_next.rdata = 8'h00;
      endcase
    end

    // source insertion, wins over same-cycle write
    st_next.src_prev = s_src;
    if (s_src && !st_reg.src_prev) begin
      st_next.cfgc[`CBF_LOW_CHARGE_LIMIT_BIT] = 1'b1;
    end

    // pin toggle releases the fault lock
    st_next.otg_prev = s_otg;
    if (s_otg != st_reg.otg_prev) begin
      st_next.pin_lock = 1'b0;
    end

    pin_on = st_reg.cfgc[`CBF_PIN_EN_BIT] &&
             (s_otg == st_reg.cfgc[`CBF_PIN_POL_BIT]) &&
             !st_reg.pin_lock && !st_reg.ovp_lock;
    boost_req = (mode == `CBF_MODE_BOOST) || pin_on;
    chg_req = is_charge_mode(mode) && !boost_req;
    rev_cond = s_rev && s_poor;

    st_next.rev_prev = rev_cond;
    if (chg_req && rev_cond && !st_reg.rev_prev) begin
      st_next.chg_evt[`CBF_EV_REV] = 1'b1;
    end
    // battery overvoltage flag on new condition
    st_next.batov_prev = s_batov;
    if (st_reg.state == cbf_pkg::CBF_CHARGE && s_batov &&
        !st_reg.batov_prev) begin
      st_next.chg_evt[`CBF_EV_BATOV] = 1'b1;
    end

    // report loop event only after it held for the delay
    if (st_reg.state == cbf_pkg::CBF_CHARGE && s_dpm) begin
      if (!st_reg.dpm_done) begin
        st_next.dpm_cnt = st_reg.dpm_cnt + 1'b1;
        if (st_reg.dpm_cnt == DPM_LAST) begin
          st_next.chg_evt[`CBF_EV_DPM] = 1'b1;
          st_next.dpm_done = 1'b1;
        end
      end
    end else begin
      st_next.dpm_cnt = '0;
      st_next.dpm_done = 1'b0;
    end

    case (st_reg.state)
      cbf_pkg::CBF_HIZ: begin
        st_next.bst_cnt = '0;
        st_next.ol_cnt = '0;
        if (boost_req) begin
          st_next.state = cbf_pkg::CBF_BOOST;
        end else if (chg_req && s_src && !rev_cond && !s_batov) begin
          st_next.state = cbf_pkg::CBF_CHARGE;
        end
      end
      cbf_pkg::CBF_CHARGE: begin
        if (boost_req) begin
          st_next.state = cbf_pkg::CBF_BOOST;
        end else if (!chg_req || !s_src || rev_cond || s_batov) begin
          st_next.state = cbf_pkg::CBF_HIZ;
        end
      end
      cbf_pkg::CBF_BOOST: begin
        // safety timer, restarted by any transaction
        st_next.bst_cnt = host_txn ? '0 : st_reg.bst_cnt + 1'b1;
        st_next.ol_cnt = s_ol ? st_reg.ol_cnt + 1'b1 : '0;
        if (!host_txn && st_reg.bst_cnt == BST_LAST) begin
          st_next.bst_evt[`CBF_EV_TMO] = 1'b1;
          bst_fault = 1'b1;
        end
        if (s_busov) begin
          // bus overvoltage, pin blocked until host writes boost mode to control
          st_next.bst_evt[`CBF_EV_BUSOV] = 1'b1;
          st_next.ovp_lock = 1'b1;
          bst_fault = 1'b1;
        end
        if (s_ol && st_reg.ol_cnt >= OLOAD_LIM) begin
          st_next.bst_evt[`CBF_EV_OLOAD] = 1'b1;
          bst_fault = 1'b1;
        end
        if (s_bmin) begin
          st_next.bst_evt[`CBF_EV_BATLOW] = 1'b1;
          bst_fault = 1'b1;
        end
        if (s_bmax) begin
          st_next.bst_evt[`CBF_EV_BATHIGH] = 1'b1;
          bst_fault = 1'b1;
        end
        if (bst_fault) begin
          // fault beats a same-cycle host write of the mode field
          st_next.ctrl[`CBF_MODE_HI:`CBF_MODE_LO] = `CBF_MODE_OFF;
          st_next.pin_lock = 1'b1;
          st_next.state = cbf_pkg::CBF_HIZ;
        end else if (!boost_req) begin
          st_next.state = cbf_pkg::CBF_HIZ;
        end
      end
      default: st_next.state = cbf_pkg::CBF_HIZ;
    endcase

    if (st_next.state != cbf_pkg::CBF_BOOST) begin
      st_next.pfm_off = 1'b0;
    end else if (!st_reg.pfm_off && s_ilow) begin
      st_next.pfm_off = 1'b1;
    end else if (st_reg.pfm_off && s_plow) begin
      st_next.pfm_off = 1'b0;
    end

    charging = st_next.state == cbf_pkg::CBF_CHARGE;
    st_next.hiz_on = st_next.state == cbf_pkg::CBF_HIZ;
    st_next.q1_on = !st_next.hiz_on;
    st_next.boost_on = st_next.state == cbf_pkg::CBF_BOOST;
    st_next.conv_on = charging ||
                      (st_next.boost_on && !st_next.pfm_off);
    st_next.short_on = charging && s_short;
    st_next.stat_oe =
      stat_drive(st_next.ctrl[`CBF_STAT_HI:`CBF_STAT_LO], charging);
    // interrupt low while any event pending
    st_next.int_n = ~(|{st_next.chg_evt, st_next.bst_evt});
  end

  // ********************************************************
  // state register
  // ********************************************************

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
      st_reg.state <= cbf_pkg::CBF_HIZ;
      st_reg.ctrl <= `CBF_CONTROL_RST;
      st_reg.cfgc <= `CBF_CONFIG_C_RST;
      st_reg.hiz_on <= 1'b1;
      st_reg.int_n <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ********************************************************
  // outputs
  // ********************************************************

  assign reg_rdata = st_reg.rdata;
  assign reverse_block_switch = st_reg.q1_on;
  assign converter_on = st_reg.conv_on;
  assign boost_mode = st_reg.boost_on;
  assign short_mode = st_reg.short_on;
  assign low_charge_limit = st_reg.cfgc[`CBF_LOW_CHARGE_LIMIT_BIT];
  assign hiz_mode = st_reg.hiz_on;
  // open-drain status: only ever pulls low
  assign stat_o = 1'b0;
  assign stat_oe = st_reg.stat_oe;
  assign int_n = st_reg.int_n;

endmodule : cbf_charger_ctrl

// [cbf_defs.svh]
// constants for the charger and boost fault control block
// assumes one 250 MHz core clock and an 8-bit register port
`ifndef CBF_DEFS_SVH
`define CBF_DEFS_SVH

// register offsets
`define CBF_ADDR_CONTROL 8'h00
`define CBF_ADDR_CONFIG_C 8'h03
`define CBF_ADDR_CHG_EVT 8'h09
`define CBF_ADDR_BST_EVT 8'h0A

// reset values
`define CBF_CONTROL_RST 8'h0A
`define CBF_CONFIG_C_RST 8'h8A
`define CBF_EVT_RST 8'h00

// control register fields
`define CBF_STAT_HI 7
`define CBF_STAT_LO 6
`define CBF_MODE_HI 1
`define CBF_MODE_LO 0

// configuration c fields
`define CBF_LOW_CHARGE_LIMIT_BIT 5
`define CBF_PIN_EN_BIT 4
`define CBF_PIN_POL_BIT 2

// charger event bits
`define CBF_EV_REV 0
`define CBF_EV_DPM 1
`define CBF_EV_BATOV 2

// boost event bits
`define CBF_EV_TMO 0
`define CBF_EV_BUSOV 1
`define CBF_EV_OLOAD 2
`define CBF_EV_BATLOW 3
`define CBF_EV_BATHIGH 4

// mode field codes
`define CBF_MODE_OFF 2'h0
`define CBF_MODE_BOOST 2'h1
`define CBF_MODE_CHG 2'h2
`define CBF_MODE_CHG_AR 2'h3

// status pin codes
`define CBF_STAT_AUTO 2'h0
`define CBF_STAT_LOW 2'h1

// timing
`define CBF_CLK_MHZ 64'd250
`define CBF_DPM_DELAY_MS 64'd32
`define CBF_OLOAD_MS 64'd30
`define CBF_BST_TMO_S 64'd32
`define CBF_TMR_W 34
`define CBF_N_CMP 13

`endif

// [cbf_pkg.sv]
// types for the charger and boost fault control block
// assumes cbf_defs.svh is on the include path
`include "cbf_defs.svh"
package cbf_pkg;

  typedef enum logic [1:0] {
    CBF_HIZ,
    CBF_CHARGE,
    CBF_BOOST
  } cbf_state_t;

  typedef struct packed {
    cbf_state_t state;
    logic [7:0] ctrl;
    logic [7:0] cfgc;
    logic [7:0] chg_evt;
    logic [7:0] bst_evt;
    logic [7:0] rdata;
    logic [`CBF_TMR_W-1:0] dpm_cnt;
    logic [`CBF_TMR_W-1:0] ol_cnt;
    logic [`CBF_TMR_W-1:0] bst_cnt;
    logic dpm_done;
    logic rev_prev;
    logic batov_prev;
    logic src_prev;
    logic otg_prev;
    logic pin_lock;
    logic ovp_lock;
    logic pfm_off;
    logic q1_on;
    logic conv_on;
    logic boost_on;
    logic short_on;
    logic hiz_on;
    logic stat_oe;
    logic int_n;
  } cbf_regs_t;

endpackage : cbf_pkg

// [cbf_sync.sv]
// two-flop synchroniser bank for asynchronous comparator levels
// assumes single core clock and asynchronous active-high reset
`timescale 1ns/1ps
module cbf_sync #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // levels
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } cbf_sync_st_t;

  cbf_sync_st_t sync_reg;
  cbf_sync_st_t sync_next;

  // first stage feeds only the second stage
  always_comb begin
    sync_next = sync_reg;
    sync_next.s1 = din;
    sync_next.s2 = sync_reg.s1;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign dout = sync_reg.s2;

endmodule : cbf_sync

// [cbf_ctrl_monitor.sv]
// checker for the charger and boost fault control ports
// assumes a bind onto cbf_charger_ctrl and one clock domain
`timescale 1ns/1ps
module cbf_ctrl_monitor #(
  parameter longint BST_TMO_CYC = 64'd40
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic i2c_txn_done,
  // fault levels
  input wire logic vbus_overvoltage,
  input wire logic boost_overload,
  input wire logic bat_above_max,
  input wire logic bat_below_min,
  // watched outputs
  input wire logic reverse_block_switch,
  input wire logic converter_on,
  input wire logic boost_mode,
  input wire logic hiz_mode,
  input wire logic stat_o,
  input wire logic stat_oe,
  input wire logic int_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic bat_bad;
  logic quiet;
  longint idle_reg;
  longint idle_next;
  assign bat_bad = bat_above_max || bat_below_min;
  assign quiet = !vbus_overvoltage && !boost_overload && !bat_bad;
  // boost time with no host traffic; margin covers output lag
  always_comb begin
    idle_next = idle_reg + 1;
    if (!boost_mode || reg_wr || reg_rd || i2c_txn_done) begin
      idle_next = 0;
    end
  end
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      idle_reg <= 0;
    end else begin
      idle_reg <= idle_next;
    end
  end
  hiz_switch_off_a: assert property (
    hiz_mode |-> !reverse_block_switch && !converter_on)
    else $error("switch or converter on in hiz");
  read_data_zero_a: assert property (
    !$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  bus_ov_stop_a: assert property (
    (boost_mode && vbus_overvoltage)[*3] |=> !boost_mode && !int_n && hiz_mode)
    else $error("boost kept running on bus overvoltage");
  bat_range_stop_a: assert property (
    (boost_mode && bat_bad)[*3] |=> !boost_mode && !int_n)
    else $error("boost kept running on battery out of range");
  boost_timer_a: assert property (
    idle_reg <= BST_TMO_CYC + 3)
    else $error("boost outlived its safety timer");
  stat_drive_low_a: assert property (
    stat_oe |-> !stat_o)
    else $error("status pin driven high");
  fault_sync_delay_a: assert property (
    boost_mode && $rose(vbus_overvoltage) && !reg_wr |=> boost_mode)
    else $error("fault acted before synchronising");
  boost_start_a: assert property (
    reg_wr && reg_addr == 8'h00 && reg_wdata[1:0] == 2'b01 && quiet
    |-> ##[1:4] boost_mode)
    else $error("mode 01 did not start boost");
  cover property ($fell(boost_mode) && hiz_mode);
  cover property ($rose(stat_oe));
  cover property ($fell(int_n));
endmodule : cbf_ctrl_monitor

bind cbf_charger_ctrl cbf_ctrl_monitor #(.BST_TMO_CYC(BST_TMO_CYC)) mon_u (
  .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .i2c_txn_done(i2c_txn_done),
  .vbus_overvoltage(vbus_overvoltage), .boost_overload(boost_overload),
  .bat_above_max(bat_above_max), .bat_below_min(bat_below_min),
  .reverse_block_switch(reverse_block_switch),
  .converter_on(converter_on), .boost_mode(boost_mode),
  .hiz_mode(hiz_mode), .stat_o(stat_o), .stat_oe(stat_oe), .int_n(int_n));

// [cbf_host_model.sv]
// host processor and transceiver side: register master, request pin
// assumes strobes are sampled on the rising edge of ref_clk
`timescale 1ns/1ps
module cbf_host_model (
  // clock
  input wire logic ref_clk,
  // register port
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // transaction pulse and request pin
  output logic i2c_txn_done,
  output logic otg_pin
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    i2c_txn_done = 1'b0;
    otg_pin = 1'b0;
  end
  // idle bus shows inverted leftovers so stale values never pass
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask : rd
  task automatic txn();
    @(posedge ref_clk);
    i2c_txn_done <= 1'b1;
    @(posedge ref_clk);
    i2c_txn_done <= 1'b0;
  endtask : txn
  task automatic pin(input logic v);
    @(posedge ref_clk);
    otg_pin <= v;
  endtask : pin
endmodule : cbf_host_model

// [cbf_charger_ctrl_tb.sv]
// testbench for the charger and boost fault control block
// assumes cbf_host_model drives the register port and request pin
`timescale 1ns/1ps
`define CK(g, e) begin checks_done++; if ((g) !== (e)) begin \
  n_mismatch++; $display("CHECK FAILED t=%0t got=%0h exp=%0h", \
  $time, g, e); end end
module cbf_charger_ctrl_tb;
  typedef struct packed {
    logic src;
    logic wr;
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } cbf_row_t;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, i2c_txn_done, otg_pin;
  logic rev = 1'b0, poor = 1'b1, dpm = 1'b0, src = 1'b0, batov = 1'b0;
  logic bshort = 1'b0, busov = 1'b0, oload = 1'b0, bmax = 1'b0;
  logic bmin = 1'b0, ilow = 1'b0, nlow = 1'b0;
  logic reverse_block_switch, converter_on, boost_mode, short_mode;
  logic low_charge_limit, hiz_mode, stat_o, stat_oe, int_n;
  int n_mismatch = 0;
  int checks_done = 0;
  int cycles = 0;
  // reads, then status writes with one config read among them: expected read data or stat_oe
  cbf_row_t rows [14] = '{
    '{1'b0, 1'b0, 8'h00, 8'h00, 8'h0A}, '{1'b0, 1'b0, 8'h03, 8'h00, 8'h8A},
    '{1'b0, 1'b0, 8'h09, 8'h00, 8'h00}, '{1'b0, 1'b0, 8'h0A, 8'h00, 8'h00},
    '{1'b0, 1'b0, 8'h05, 8'h00, 8'h00}, '{1'b0, 1'b1, 8'h00, 8'h02, 8'h00},
    '{1'b1, 1'b1, 8'h00, 8'h02, 8'h01}, '{1'b1, 1'b1, 8'h00, 8'h42, 8'h01},
    '{1'b1, 1'b1, 8'h00, 8'h82, 8'h00}, '{1'b1, 1'b1, 8'h00, 8'hC2, 8'h00},
    '{1'b1, 1'b0, 8'h03, 8'h00, 8'hAA}, '{1'b1, 1'b1, 8'h00, 8'h03, 8'h01},
    '{1'b1, 1'b1, 8'h00, 8'h43, 8'h01}, '{1'b1, 1'b1, 8'h00, 8'h00, 8'h00}};
  always #2 ref_clk = ~ref_clk;
  cbf_host_model hst (.ref_clk(ref_clk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .i2c_txn_done(i2c_txn_done), .otg_pin(otg_pin));
  // short counts keep the run brief
  cbf_charger_ctrl #(.DPM_CYC(20), .OLOAD_CYC(16), .BST_TMO_CYC(40)) dut_u (
    .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .i2c_txn_done(i2c_txn_done),
    .vbus_below_rev(rev), .vbus_above_poor(poor),
    .input_voltage_power_loop(dpm), .source_valid(src),
    .bat_overvoltage(batov), .bat_below_short(bshort),
    .vbus_overvoltage(busov), .boost_overload(oload),
    .bat_above_max(bmax), .bat_below_min(bmin), .ind_current_low(ilow),
    .boost_output_node_low(nlow), .otg_pin(otg_pin),
    .reverse_block_switch(reverse_block_switch),
    .converter_on(converter_on), .boost_mode(boost_mode),
    .short_mode(short_mode), .low_charge_limit(low_charge_limit),
    .hiz_mode(hiz_mode), .stat_o(stat_o), .stat_oe(stat_oe), .int_n(int_n));
  task automatic report_and_stop();
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop
  // synchroniser plus one registered stage, with a spare edge
  task automatic settle();
    repeat (4) @(posedge ref_clk);
    #1;
  endtask : settle
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    hst.rd(a, d);
    `CK(d, e)
  endtask : rchk
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 0; i < 14; i++) begin
      @(posedge ref_clk) src <= rows[i].src;
      if (rows[i].wr) begin
        hst.wr(rows[i].a, rows[i].d);
        settle();
        `CK({6'h00, stat_o, stat_oe}, rows[i].e)
      end else begin
        rchk(rows[i].a, rows[i].e);
      end
    end
    `CK(hiz_mode, 1'b1)
    `CK(low_charge_limit, 1'b1)
    hst.wr(8'h03, 8'h9E);
    hst.wr(8'h00, 8'h02);
    settle();
    `CK(low_charge_limit, 1'b0)
    @(posedge ref_clk) dpm <= 1'b1;
    repeat (12) @(posedge ref_clk);
    #1;
    `CK(int_n, 1'b1)
    repeat (20) @(posedge ref_clk);
    #1;
    `CK(int_n, 1'b0)
    rchk(8'h09, 8'h02);
    `CK(int_n, 1'b1)
    @(posedge ref_clk) dpm <= 1'b0;
    batov <= 1'b1;
    settle();
    `CK({hiz_mode, converter_on}, 2'b10)
    rchk(8'h09, 8'h04);
    @(posedge ref_clk) batov <= 1'b0;
    settle();
    `CK(hiz_mode, 1'b0)
    @(posedge ref_clk) bshort <= 1'b1;
    settle();
    `CK(short_mode, 1'b1)
    @(posedge ref_clk) bshort <= 1'b0;
    rev <= 1'b1;
    poor <= 1'b0;
    settle();
    // a dead source below the poor threshold must not trip reverse
    `CK(hiz_mode, 1'b0)
    @(posedge ref_clk) poor <= 1'b1;
    settle();
    `CK({hiz_mode, reverse_block_switch}, 2'b10)
    rchk(8'h09, 8'h01);
    @(posedge ref_clk) rev <= 1'b0;
    src <= 1'b0;
    hst.wr(8'h00, 8'h01);
    settle();
    `CK({boost_mode, hiz_mode}, 2'b10)
    @(posedge ref_clk) ilow <= 1'b1;
    settle();
    `CK(converter_on, 1'b0)
    @(posedge ref_clk) ilow <= 1'b0;
    nlow <= 1'b1;
    settle();
    `CK(converter_on, 1'b1)
    @(posedge ref_clk) nlow <= 1'b0;
    repeat (3) begin
      hst.txn();
      repeat (25) @(posedge ref_clk);
    end
    settle();
    `CK(boost_mode, 1'b1)
    repeat (50) @(posedge ref_clk);
    #1;
    `CK({boost_mode, hiz_mode}, 2'b01)
    rchk(8'h0A, 8'h01);
    rchk(8'h0A, 8'h00);
    hst.wr(8'h00, 8'h01);
    settle();
    @(posedge ref_clk) busov <= 1'b1;
    settle();
    `CK(boost_mode, 1'b0)
    rchk(8'h00, 8'h00);
    rchk(8'h0A, 8'h02);
    @(posedge ref_clk) busov <= 1'b0;
    settle();
    `CK(boost_mode, 1'b0)
    hst.wr(8'h00, 8'h01);
    @(posedge ref_clk) oload <= 1'b1;
    repeat (10) @(posedge ref_clk);
    oload <= 1'b0;
    settle();
    `CK(boost_mode, 1'b1)
    hst.txn();
    @(posedge ref_clk) oload <= 1'b1;
    repeat (24) @(posedge ref_clk);
    oload <= 1'b0;
    settle();
    `CK(boost_mode, 1'b0)
    rchk(8'h0A, 8'h04);
    hst.pin(1'b1);
    settle();
    `CK(boost_mode, 1'b1)
    hst.pin(1'b0);
    settle();
    `CK(boost_mode, 1'b0)
    hst.wr(8'h03, 8'h9A);
    settle();
    `CK(boost_mode, 1'b1)
    hst.pin(1'b1);
    settle();
    `CK(boost_mode, 1'b0)
    hst.wr(8'h03, 8'h9E);
    @(posedge ref_clk) bmin <= 1'b1;
    settle();
    `CK(boost_mode, 1'b0)
    rchk(8'h0A, 8'h08);
    @(posedge ref_clk) bmin <= 1'b0;
    hst.pin(1'b0);
    hst.pin(1'b1);
    settle();
    `CK(boost_mode, 1'b1)
    @(posedge ref_clk) bmax <= 1'b1;
    settle();
    `CK(boost_mode, 1'b0)
    rchk(8'h0A, 8'h10);
    `CK(int_n, 1'b1)
    @(posedge ref_clk) bmax <= 1'b0;
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    `CK({hiz_mode, int_n}, 2'b11)
    @(posedge ref_clk) rst <= 1'b0;
    rchk(8'h00, 8'h0A);
    report_and_stop();
  end
endmodule : cbf_charger_ctrl_tb
